// *** pesl_top.sv ***
// Error flag collection, run/stop and indicator control of a controller CPU.
// Assumes fault inputs are clock-synchronous one-cycle pulses unless noted.
`timescale 1ns/10ps
module pesl_top
    import pesl_pkg::*;
#(
    parameter logic [WDT_W-1:0] WDT_CYCLES = WDT_W'(WDT_CYCLES_DEF)
)
(
    input  wire logic              i_core_clk,
    input  wire logic              i_sys_rst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_rd,
    output logic      [DATA_W-1:0] o_rdata,
    input  wire logic              i_supply_low,
    input  wire logic              i_power_off,
    input  wire logic              i_scan_done,
    input  wire logic              i_link_init_strobe,
    input  wire logic              i_link_init_err,
    input  wire logic [4:0]        i_link_station_num,
    input  wire logic              i_cart_fitted,
    input  wire logic              i_prog_sum_bad_int,
    input  wire logic              i_prog_sum_bad_cart,
    input  wire logic              i_preset_sum_bad,
    input  wire logic              i_ram_sum_bad,
    input  wire logic              i_reload_done,
    input  wire logic              i_keep_bad,
    input  wire logic              i_syntax_bad,
    input  wire logic              i_prog_xfer_ok,
    input  wire logic              i_write_fail_int,
    input  wire logic              i_write_fail_cart,
    input  wire logic              i_write_ok,
    input  wire logic              i_nv_missing,
    input  wire logic              i_clock_bad,
    input  wire logic              i_clock_rewrite,
    input  wire logic              i_io_fault,
    input  wire logic              i_exec_req,
    input  wire logic [3:0]        i_exec_kind,
    input  wire logic [15:0]       i_wk_day,
    input  wire logic [15:0]       i_wk_t_on,
    input  wire logic [15:0]       i_wk_t_off,
    input  wire logic [1:0]        i_wk_mode,
    input  wire logic              i_wk_tbl_prog,
    input  wire logic              i_wk_tbl_exec,
    output logic                   o_run,
    output logic                   o_out_en,
    output logic                   o_err_led,
    output logic                   o_exec_fault_flag_bit,
    output logic                   o_link_reinit,
    output logic                   o_preset_reload,
    output logic                   o_recompile,
    output logic                   o_keep_clear
);

    typedef struct packed {
        pesl_state_t       state;
        logic [15:0]       flags;
        logic [15:0]       exec_code;
        logic              exec_flag;
        logic              keep_stop;
        logic [WDT_W-1:0]  wdt_cnt;
        logic [DATA_W-1:0] rdata;
        logic              run;
        logic              out_en;
        logic              led;
        logic              link_reinit;
        logic              preset_reload;
        logic              recompile;
        logic              keep_clear;
    } pesl_st_t;

    pesl_st_t s_r;
    pesl_st_t s_nxt;

    pesl_exec_if ex ();

    assign ex.req      = i_exec_req;
    assign ex.kind     = pesl_exec_kind_t'(i_exec_kind);
    assign ex.day      = i_wk_day;
    assign ex.t_on     = i_wk_t_on;
    assign ex.t_off    = i_wk_t_off;
    assign ex.wk_mode  = i_wk_mode;
    assign ex.tbl_prog = i_wk_tbl_prog;
    assign ex.tbl_exec = i_wk_tbl_exec;

    pesl_exec_chk u_exec_chk (
        .i_core_clk (i_core_clk),
        .i_sys_rst  (i_sys_rst),
        .x          (ex)
    );

    always_comb begin
        logic        ctl_wr;
        logic        clr;
        logic [15:0] set;
        logic [15:0] auto_clr;
        logic [15:0] held;
        logic [15:0] stop_mask;
        logic        wdt_exp;

        ctl_wr   = i_wr && (i_addr == REG_CTRL);
        clr      = ctl_wr && i_wdata[CTL_CLR];
        set       = '0;
        auto_clr  = '0;
        held      = '0;
        stop_mask = STOP_MASK;
        wdt_exp   = 1'b0;

        s_nxt               = s_r;
        s_nxt.rdata         = '0;
        s_nxt.link_reinit   = 1'b0;
        s_nxt.preset_reload = 1'b0;
        s_nxt.recompile     = 1'b0;
        s_nxt.keep_clear    = 1'b0;

        if (ctl_wr) begin
            s_nxt.keep_stop   = i_wdata[CTL_KEEP_STOP];
            s_nxt.link_reinit = i_wdata[CTL_LINK_REINIT];
        end

        // Scan watchdog only counts while the program is actually running
        if (!s_r.run || i_scan_done) begin
            s_nxt.wdt_cnt = '0;
        end else if (s_r.wdt_cnt >= WDT_CYCLES - WDT_W'(1)) begin
            wdt_exp       = 1'b1;
            s_nxt.wdt_cnt = '0;
        end else begin
            s_nxt.wdt_cnt = s_r.wdt_cnt + WDT_W'(1);
        end

        set[FLG_PWR]        = i_supply_low | i_power_off;
        set[FLG_WDT]        = wdt_exp;
        set[FLG_LINK]       = i_link_init_strobe
                              && (i_link_init_err || (i_link_station_num == 5'h00));
        set[FLG_PROG_SUM]   = i_cart_fitted ? i_prog_sum_bad_cart : i_prog_sum_bad_int;
        set[FLG_PRESET_SUM] = i_preset_sum_bad;
        set[FLG_RAM_SUM]    = i_ram_sum_bad;
        set[FLG_KEEP]       = i_keep_bad;
        set[FLG_SYNTAX]     = i_syntax_bad;
        set[FLG_WRITE]      = i_cart_fitted ? i_write_fail_cart : i_write_fail_int;
        set[FLG_NV_MISSING] = i_nv_missing;
        set[FLG_CLOCK]      = i_clock_bad;
        set[FLG_IO_BUS]     = i_io_fault;

        auto_clr[FLG_SYNTAX] = i_prog_xfer_ok;
        auto_clr[FLG_WRITE]  = i_write_ok;
        auto_clr[FLG_CLOCK]  = i_clock_rewrite;

        // A fault arriving in the clearing cycle survives: set is applied last
        held = s_r.flags & ~auto_clr;
        if (clr) begin
            held = '0;
        end
        s_nxt.flags = held | set;

        s_nxt.preset_reload = i_preset_sum_bad | i_ram_sum_bad;
        s_nxt.recompile     = i_ram_sum_bad;
        s_nxt.keep_clear    = i_keep_bad;

        if (clr) begin
            s_nxt.exec_flag = 1'b0;
        end
        if (ex.hit) begin
            s_nxt.exec_flag = 1'b1;
            s_nxt.exec_code = ex.code;
        end

        unique case (s_r.state)
            ST_RUN: begin
                if (i_ram_sum_bad) begin
                    s_nxt.state = ST_RELOAD;
                end
            end
            ST_RELOAD: begin
                if (i_reload_done) begin
                    s_nxt.state = ST_RUN;
                end
            end
        endcase

        stop_mask[FLG_KEEP] = s_nxt.keep_stop;
        s_nxt.run    = ~|(s_nxt.flags & stop_mask) && (s_nxt.state == ST_RUN);
        s_nxt.out_en = s_nxt.run;
        s_nxt.led    = |(s_nxt.flags & LED_MASK) || s_nxt.exec_flag;

        if (i_rd) begin
            unique case (i_addr)
                REG_FLAGS:     s_nxt.rdata = s_r.flags;
                REG_EXEC_CODE: s_nxt.rdata = s_r.exec_code;
                REG_CTRL:      s_nxt.rdata = {14'h0000, s_r.keep_stop, 1'b0};
                REG_STATUS:    s_nxt.rdata = {11'h000, (s_r.state == ST_RELOAD), s_r.exec_flag,
                                              s_r.led, s_r.out_en, s_r.run};
                default:       s_nxt.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_r           <= '0;
            s_r.state     <= ST_RUN;
            s_r.flags     <= FLAGS_RST;
            s_r.exec_code <= CODE_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign o_rdata               = s_r.rdata;
    assign o_run                 = s_r.run;
    assign o_out_en              = s_r.out_en;
    assign o_err_led             = s_r.led;
    assign o_exec_fault_flag_bit = s_r.exec_flag;
    assign o_link_reinit         = s_r.link_reinit;
    assign o_preset_reload       = s_r.preset_reload;
    assign o_recompile           = s_r.recompile;
    assign o_keep_clear          = s_r.keep_clear;

endmodule : pesl_top

// *** pesl_pkg.sv ***
// Constants, types and register map of the controller error status logic.
// Assumes a single 10 MHz core clock and a plain word-addressed register port.
package pesl_pkg;

    localparam int          CLK_KHZ         = 10000;
    localparam int          WDT_TIME_MS     = 293;
    localparam int          WDT_CYCLES_DEF  = WDT_TIME_MS * CLK_KHZ;
    localparam int          WDT_W           = 22;

    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 16;
    localparam logic [3:0]  REG_FLAGS       = 4'h0;
    localparam logic [3:0]  REG_EXEC_CODE   = 4'h1;
    localparam logic [3:0]  REG_CTRL        = 4'h2;
    localparam logic [3:0]  REG_STATUS      = 4'h3;

    localparam int          CTL_CLR         = 0;
    localparam int          CTL_KEEP_STOP   = 1;
    localparam int          CTL_LINK_REINIT = 2;

    localparam int          STS_RUN         = 0;
    localparam int          STS_OUT_EN      = 1;
    localparam int          STS_ERR_LED     = 2;
    localparam int          STS_EXEC_FAULT  = 3;
    localparam int          STS_RELOAD      = 4;

    localparam int          FLG_PWR         = 0;
    localparam int          FLG_WDT         = 1;
    localparam int          FLG_LINK        = 2;
    localparam int          FLG_PROG_SUM    = 3;
    localparam int          FLG_PRESET_SUM  = 4;
    localparam int          FLG_RAM_SUM     = 5;
    localparam int          FLG_KEEP        = 6;
    localparam int          FLG_SYNTAX      = 7;
    localparam int          FLG_WRITE       = 8;
    localparam int          FLG_NV_MISSING  = 9;
    localparam int          FLG_CLOCK       = 10;
    localparam int          FLG_IO_BUS      = 13;

    localparam logic [15:0] STOP_MASK       = 16'h238f;
    localparam logic [15:0] LED_MASK        = 16'h27aa;
    localparam logic [15:0] FLAGS_RST       = 16'h0000;
    localparam logic [15:0] CODE_RST        = 16'h0000;

    localparam logic [15:0] CODE_OPERAND    = 16'h0001;
    localparam logic [15:0] CODE_MUL        = 16'h0002;
    localparam logic [15:0] CODE_DIV        = 16'h0003;
    localparam logic [15:0] CODE_DSHIFT     = 16'h0004;
    localparam logic [15:0] CODE_B2D        = 16'h0005;
    localparam logic [15:0] CODE_D2B        = 16'h0006;
    localparam logic [15:0] CODE_DIGITS     = 16'h0007;
    localparam logic [15:0] CODE_NONASCII   = 16'h0008;
    localparam logic [15:0] CODE_WK_RANGE   = 16'h0009;
    localparam logic [15:0] CODE_WK_TABLE   = 16'h000a;

    localparam logic [15:0] WK_DAY_MAX      = 16'h007f;
    localparam logic [15:0] WK_HOUR_MAX     = 16'h0017;
    localparam logic [15:0] WK_MIN_MAX      = 16'h003b;
    localparam logic [15:0] WK_TIME_OFF     = 16'h2710;
    localparam logic [15:0] WK_HUNDRED      = 16'h0064;
    localparam logic [1:0]  WK_MODE_ADD     = 2'h1;
    localparam logic [1:0]  WK_MODE_SKIP    = 2'h2;

    typedef enum logic [3:0] {
        EK_OPERAND,
        EK_MUL,
        EK_DIV,
        EK_DSHIFT,
        EK_B2D,
        EK_D2B,
        EK_DIGITS,
        EK_NONASCII,
        EK_WEEKLY
    } pesl_exec_kind_t;

    typedef enum logic {
        ST_RUN,
        ST_RELOAD
    } pesl_state_t;

endpackage : pesl_pkg

// *** pesl_exec_if.sv ***
// Execution fault request and classified answer between core and checker.
// Assumes both ends share the core clock.
`timescale 1ns/10ps
interface pesl_exec_if;
    import pesl_pkg::*;
    logic            req;
    pesl_exec_kind_t kind;
    logic [15:0]     day;
    logic [15:0]     t_on;
    logic [15:0]     t_off;
    logic [1:0]      wk_mode;
    logic            tbl_prog;
    logic            tbl_exec;
    logic            hit;
    logic [15:0]     code;

    modport core (output req, kind, day, t_on, t_off, wk_mode, tbl_prog, tbl_exec, input hit, code);
    modport chk  (input req, kind, day, t_on, t_off, wk_mode, tbl_prog, tbl_exec, output hit, code);
endinterface : pesl_exec_if

// *** pesl_exec_chk.sv ***
// Classifies an execution fault into its detail code, one cycle after the request.
// Assumes the request is a one-cycle pulse with operands stable beside it.
`timescale 1ns/10ps
module pesl_exec_chk
    import pesl_pkg::*;
(
    input  wire logic i_core_clk,
    input  wire logic i_sys_rst,
    pesl_exec_if.chk  x
);

    typedef struct packed {
        logic        hit;
        logic [15:0] code;
    } pesl_chk_st_t;

    pesl_chk_st_t s_r;
    pesl_chk_st_t s_nxt;

    // Time operand is hours*100+minutes; the disable value passes as well
    function automatic logic time_ok(input logic [15:0] v);
        logic [15:0] hr;
        logic [15:0] mn;
        hr = v / WK_HUNDRED;
        mn = v % WK_HUNDRED;
        time_ok = (v == WK_TIME_OFF) || ((hr <= WK_HOUR_MAX) && (mn <= WK_MIN_MAX));
    endfunction : time_ok

    always_comb begin
        logic range_bad;
        logic tbl_bad;
        range_bad = (x.day > WK_DAY_MAX) || !time_ok(x.t_on) || !time_ok(x.t_off);
        tbl_bad   = ((x.wk_mode == WK_MODE_ADD) || (x.wk_mode == WK_MODE_SKIP))
                    && (!x.tbl_prog || !x.tbl_exec);
        s_nxt     = s_r;
        s_nxt.hit = 1'b0;
        if (x.req) begin
            s_nxt.hit = 1'b1;
            unique case (x.kind)
                EK_OPERAND:  s_nxt.code = CODE_OPERAND;
                EK_MUL:      s_nxt.code = CODE_MUL;
                EK_DIV:      s_nxt.code = CODE_DIV;
                EK_DSHIFT:   s_nxt.code = CODE_DSHIFT;
                EK_B2D:      s_nxt.code = CODE_B2D;
                EK_D2B:      s_nxt.code = CODE_D2B;
                EK_DIGITS:   s_nxt.code = CODE_DIGITS;
                EK_NONASCII: s_nxt.code = CODE_NONASCII;
                EK_WEEKLY: begin
                    if (range_bad) begin
                        s_nxt.code = CODE_WK_RANGE;
                    end else if (tbl_bad) begin
                        s_nxt.code = CODE_WK_TABLE;
                    end else begin
                        s_nxt.hit = 1'b0;
                    end
                end
                default:     s_nxt.hit = 1'b0;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign x.hit  = s_r.hit;
    assign x.code = s_r.code;

endmodule : pesl_exec_chk

// *** pesl_chk_properties.sv ***
// Port-level timing checks of the controller error status logic.
// Assumes it is bound into pesl_top and sees only its ports.
`timescale 1ns/10ps
module pesl_chk_props
    import pesl_pkg::*;
(
    input  wire logic              i_core_clk,
    input  wire logic              i_sys_rst,
    input  wire logic [ADDR_W-1:0] i_addr,
    input  wire logic [DATA_W-1:0] i_wdata,
    input  wire logic              i_wr,
    input  wire logic              i_supply_low,
    input  wire logic              i_cart_fitted,
    input  wire logic              i_prog_sum_bad_int,
    input  wire logic              i_preset_sum_bad,
    input  wire logic              i_ram_sum_bad,
    input  wire logic              i_keep_bad,
    input  wire logic              i_clock_bad,
    input  wire logic              i_io_fault,
    input  wire logic              i_link_init_strobe,
    input  wire logic              i_link_init_err,
    input  wire logic              i_exec_req,
    input  wire logic [3:0]        i_exec_kind,
    input  wire logic              o_run,
    input  wire logic              o_out_en,
    input  wire logic              o_err_led,
    input  wire logic              o_exec_fault_flag_bit,
    input  wire logic              o_link_reinit,
    input  wire logic              o_preset_reload,
    input  wire logic              o_recompile,
    input  wire logic              o_keep_clear
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    chk_pwr_stop: assert property (i_supply_low |=> !o_run && !o_out_en)
        else $error("power loss left outputs on");
    chk_link_stop: assert property (i_link_init_strobe && i_link_init_err |=> !o_run && !o_out_en)
        else $error("link fault did not stop");
    chk_link_pulse: assert property (i_wr && i_addr == REG_CTRL && i_wdata[CTL_LINK_REINIT] |=> o_link_reinit)
        else $error("link restart pulse missing");
    chk_prog_stop: assert property (i_prog_sum_bad_int && !i_cart_fitted |=> !o_run && o_err_led)
        else $error("program checksum fault did not stop");
    chk_preset_go: assert property (i_preset_sum_bad |=> o_preset_reload && o_run)
        else $error("preset reload missing");
    chk_ram_reload: assert property (i_ram_sum_bad |=> o_recompile && o_preset_reload && o_err_led && !o_run)
        else $error("ram checksum reaction wrong");
    chk_reload_halt: assert property (o_recompile |-> !o_out_en ##1 !o_out_en)
        else $error("outputs back on during reload");
    chk_keep_clear: assert property (i_keep_bad |=> o_keep_clear)
        else $error("retained clear pulse missing");
    chk_clock_led: assert property (i_clock_bad |=> o_err_led && o_run)
        else $error("clock fault reaction wrong");
    chk_io_stop: assert property (i_io_fault |=> !o_out_en && o_err_led)
        else $error("io fault did not stop");
    chk_exec_led: assert property (i_exec_req && i_exec_kind == 4'h1 |-> ##2 o_exec_fault_flag_bit && o_err_led)
        else $error("execution fault not flagged");
endmodule : pesl_chk_props

bind pesl_top pesl_chk_props u_props (.*);

// *** pesl_host_model.sv ***
// Behavioural programming station that reads and clears the error registers.
// Assumes the bench calls one task at a time after reset.
`timescale 1ns/10ps
module pesl_host_model
    import pesl_pkg::*;
(
    input  wire logic              i_core_clk,
    output logic      [ADDR_W-1:0] o_addr,
    output logic      [DATA_W-1:0] o_wdata,
    output logic                   o_wr,
    output logic                   o_rd
);
    initial begin
        o_addr = '0;
        o_wdata = '0;
        o_wr = 1'h0;
        o_rd = 1'h0;
    end

    // Released data is inverted so a stale value can never look valid
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge i_core_clk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'h1;
        @(posedge i_core_clk);
        o_wr <= 1'h0;
        o_wdata <= ~d;
    endtask : wr

    task automatic rd(input logic [ADDR_W-1:0] a);
        @(posedge i_core_clk);
        o_addr <= a;
        o_rd <= 1'h1;
        @(posedge i_core_clk);
        o_rd <= 1'h0;
    endtask : rd

    task automatic clear(input logic keep);
        wr(REG_CTRL, {14'h0, keep, 1'h1});
    endtask : clear
endmodule : pesl_host_model

// *** tb_top.sv ***
// Self-checking bench of the error status logic with a host model on the register port.
// Assumes a shortened watchdog count; all fault inputs except the level-held i_link_init_err are one-cycle pulses.
`timescale 1ns/10ps
module tb_top;
    import pesl_pkg::*;
    localparam int WDT = 20;
    logic i_core_clk = 1'h0, i_sys_rst = 1'h1, i_rd, i_wr, rd_d = 1'h0, scan = 1'h0, hold = 1'h0;
    logic [ADDR_W-1:0] i_addr;
    logic [DATA_W-1:0] i_wdata, o_rdata;
    logic [17:0] ev = '0;
    logic err = 1'h1, cart = 1'h0, xreq = 1'h0, tprog = 1'h0, texec = 1'h0;
    logic [4:0] stn = 5'h1;
    logic [3:0] kind = '0;
    logic [1:0] mode = '0;
    logic [15:0] day = '0, ton = '0, toff = '0;
    logic [7:0] cyc = '0;
    logic [19:0] exp_q[$], note;
    int fail_count = 0, n_checks = 0, seed = 32'h6bdf;
    logic o_run, o_out_en, o_err_led, o_exec_fault_flag_bit;
    logic o_link_reinit, o_preset_reload, o_recompile, o_keep_clear;
    // Pulse tallies: link restart, preset reload, recompile, retained clear
    int n_pls[4] = '{0, 0, 0, 0};
    int pls_exp[4] = '{1, 3, 2, 2};
    // ev: power_off link prog_int preset ram keep syntax wfail_int nv clock io prog_cart
    //     reload_done xfer_ok write_ok clock_rewrite wfail_cart supply_low
    int unsigned eb[11] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 17};
    logic [15:0] ef[11] = '{16'h1, 16'h4, 16'h8, 16'h10, 16'h40, 16'h80, 16'h100, 16'h200, 16'h400, 16'h2000, 16'h1};
    logic [15:0] es[11] = '{16'h0, 16'h0, 16'h4, 16'h3, 16'h3, 16'h4, 16'h4, 16'h4, 16'h7, 16'h4, 16'h0};
    // Weekly cases: day, on, off, mode[13:12], prog[9], exec[8], code[7:4], fault[0]
    logic [63:0] wk[7] = '{64'h0080_0000_0000_1391, 64'h007f_0937_2710_1390, 64'h007f_0000_0000_21a1,
        64'h007f_0938_0000_0391, 64'h007f_0000_0000_12a1, 64'h007f_0000_0960_0391, 64'h0000_0000_0000_0090};

    pesl_host_model u_host (.i_core_clk(i_core_clk), .o_addr(i_addr), .o_wdata(i_wdata), .o_wr(i_wr), .o_rd(i_rd));

    pesl_top #(.WDT_CYCLES(WDT_W'(WDT))) DUT (
        .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_supply_low(ev[17]), .i_power_off(ev[0]), .i_scan_done(scan),
        .i_link_init_strobe(ev[1]), .i_link_init_err(err), .i_link_station_num(stn), .i_cart_fitted(cart),
        .i_prog_sum_bad_int(ev[2]), .i_prog_sum_bad_cart(ev[11]), .i_preset_sum_bad(ev[3]), .i_ram_sum_bad(ev[4]),
        .i_reload_done(ev[12]), .i_keep_bad(ev[5]), .i_syntax_bad(ev[6]), .i_prog_xfer_ok(ev[13]),
        .i_write_fail_int(ev[7]), .i_write_fail_cart(ev[16]), .i_write_ok(ev[14]), .i_nv_missing(ev[8]),
        .i_clock_bad(ev[9]), .i_clock_rewrite(ev[15]), .i_io_fault(ev[10]), .i_exec_req(xreq), .i_exec_kind(kind),
        .i_wk_day(day), .i_wk_t_on(ton), .i_wk_t_off(toff), .i_wk_mode(mode), .i_wk_tbl_prog(tprog),
        .i_wk_tbl_exec(texec), .o_run(o_run), .o_out_en(o_out_en), .o_err_led(o_err_led),
        .o_exec_fault_flag_bit(o_exec_fault_flag_bit), .o_link_reinit(o_link_reinit),
        .o_preset_reload(o_preset_reload), .o_recompile(o_recompile), .o_keep_clear(o_keep_clear));

    initial begin
        forever #50 i_core_clk = ~i_core_clk;
    end

    // Program cycles end every 8 clocks unless the watchdog scenario holds them off
    always @(posedge i_core_clk) begin
        cyc <= cyc + 8'h1;
        scan <= !hold && (cyc[2:0] == 3'h0);
    end

    always @(posedge i_core_clk) begin
        rd_d <= i_rd;
        if (rd_d) begin
            note = exp_q.pop_front();
            n_checks++;
            if (o_rdata !== note[15:0]) begin
                fail_count++;
                $display("[FAIL] reg %h expected %h seen %h", note[19:16], note[15:0], o_rdata);
            end
            // The status word lags the pins by one cycle; every status read follows a settled state
            if (note[19:16] == REG_STATUS) begin
                n_checks++;
                if ({o_exec_fault_flag_bit, o_err_led, o_out_en, o_run} !== note[3:0]) begin
                    fail_count++;
                    $display("[FAIL] pins expected %h seen %h", note[3:0],
                             {o_exec_fault_flag_bit, o_err_led, o_out_en, o_run});
                end
            end
        end
    end

    always @(posedge i_core_clk) begin
        if (!i_sys_rst) begin
            n_pls[0] <= n_pls[0] + int'(o_link_reinit);
            n_pls[1] <= n_pls[1] + int'(o_preset_reload);
            n_pls[2] <= n_pls[2] + int'(o_recompile);
            n_pls[3] <= n_pls[3] + int'(o_keep_clear);
        end
    end

    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        exp_q.push_back({a, e});
        u_host.rd(a);
    endtask : rd

    task automatic chk(input logic [15:0] f, input logic [15:0] s);
        rd(REG_FLAGS, f);
        rd(REG_STATUS, s);
    endtask : chk

    task automatic pulse(input int unsigned b);
        @(posedge i_core_clk);
        ev[b] <= 1'h1;
        @(posedge i_core_clk);
        ev[b] <= 1'h0;
    endtask : pulse

    task automatic exec(input logic [3:0] k, input logic [63:0] w);
        @(posedge i_core_clk);
        {day, ton, toff} <= w[63:16];
        mode <= w[13:12];
        {tprog, texec} <= w[9:8];
        kind <= k;
        xreq <= 1'h1;
        @(posedge i_core_clk);
        xreq <= 1'h0;
        repeat (3) @(posedge i_core_clk);
    endtask : exec

    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    initial begin
        #2000000;
        fail_count++;
        end_sim;
    end

    initial begin
        repeat (6) @(posedge i_core_clk);
        i_sys_rst <= 1'h0;
        chk(16'h0, 16'h3);
        rd(REG_EXEC_CODE, 16'h0);
        u_host.wr(REG_FLAGS, 16'hffff);
        rd(REG_FLAGS, 16'h0);
        rd(4'h7, 16'h0);
        for (int i = 0; i < 11; i++) begin
            pulse(eb[i]);
            chk(ef[i], es[i]);
            u_host.clear(1'h0);
            chk(16'h0, 16'h3);
        end
        pulse(4);
        pulse(0);
        chk(16'h21, 16'h14);
        repeat (10) @(posedge i_core_clk);
        pulse(12);
        chk(16'h21, 16'h4);
        u_host.clear(1'h0);
        pulse(4);
        chk(16'h20, 16'h14);
        pulse(12);
        chk(16'h20, 16'h7);
        u_host.clear(1'h1);
        rd(REG_CTRL, 16'h2);
        pulse(5);
        chk(16'h40, 16'h0);
        u_host.clear(1'h0);
        cart <= 1'h1;
        pulse(2);
        pulse(11);
        pulse(16);
        chk(16'h108, 16'h4);
        pulse(14);
        chk(16'h8, 16'h4);
        u_host.clear(1'h0);
        cart <= 1'h0;
        for (int i = 6; i < 10; i++) begin
            pulse((i == 8) ? 7 : i);
            pulse((i == 6) ? 13 : (i == 9) ? 15 : 14);
            chk(16'h0, 16'h3);
        end
        err <= 1'h0;
        stn <= 5'h0;
        pulse(1);
        chk(16'h4, 16'h0);
        u_host.clear(1'h0);
        stn <= 5'(1 + ($unsigned($random(seed)) % 31));
        pulse(1);
        chk(16'h0, 16'h3);
        u_host.wr(REG_CTRL, 16'h4);
        rd(REG_CTRL, 16'h0);
        hold <= 1'h1;
        repeat (WDT + 10) @(posedge i_core_clk);
        chk(16'h2, 16'h4);
        hold <= 1'h0;
        u_host.clear(1'h0);
        for (int k = 0; k < 8; k++) begin
            exec(k[3:0], {$random(seed), $random(seed)});
            rd(REG_EXEC_CODE, 16'(k + 1));
            rd(REG_STATUS, 16'hf);
            u_host.clear(1'h0);
        end
        for (int i = 0; i < 7; i++) begin
            exec(4'h8, wk[i]);
            rd(REG_EXEC_CODE, {12'h0, wk[i][7:4]});
            rd(REG_STATUS, wk[i][0] ? 16'hf : 16'h3);
            u_host.clear(1'h0);
        end
        exec(4'hf, wk[0]);
        rd(REG_EXEC_CODE, 16'h9);
        rd(REG_STATUS, 16'h3);
        repeat (4) @(posedge i_core_clk);
        for (int i = 0; i < 4; i++) begin
            n_checks++;
            if (n_pls[i] != pls_exp[i]) begin
                fail_count++;
                $display("[FAIL] pulse count %0d expected %0d seen %0d", i, pls_exp[i], n_pls[i]);
            end
        end
        end_sim;
    end
endmodule : tb_top
